// ### tb_top.sv
// Self-checking bench for the calibration and CA training decoder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb_top
  import zqc_pkg::*;
;
  logic clk_sys, rst, ck_t, cke, cs_n, odt_pin;
  logic [9:0] ca, r, f;
  logic [15:0] dq_o, dq_oe;
  logic dqs_oe, odt_on, zq_pin_en, cal_busy, imp_default, train_mode, remap_mode;
  int bad_count = 0;
  int samples_checked = 0;
  int busy_cyc = 0;
  int pin_cyc = 0;
  int cycles = 0;
  // Entry write pattern, the same on both memory clock edges.
  localparam logic [9:0] ENT_CA = {ZQC_OP_ENTRY, ZQC_MR_ENTRY[7:6]};

  zqc_top zqc_top_i (.clk_sys(clk_sys), .rst(rst), .ck_t(ck_t), .cke(cke), .cs_n(cs_n),
    .ca(ca), .odt_pin(odt_pin), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_oe(dqs_oe), .odt_on(odt_on),
    .zq_pin_en(zq_pin_en), .cal_busy(cal_busy), .imp_default(imp_default),
    .train_mode(train_mode), .remap_mode(remap_mode));
  zqc_ctrl_model zqc_ctrl_model_i (.clk_sys(clk_sys), .ck_t(ck_t), .cke(cke), .cs_n(cs_n),
    .ca(ca));

  // ----------------------------------------
  // Clock, cycle counters and hang guard
  // ----------------------------------------
  // The 20 MHz system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Counting busy cycles avoids guessing the exact decode edge; the ceiling stops a hang.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cal_busy === 1'b1)
      busy_cyc++;
    if (zq_pin_en === 1'b1)
      pin_cyc++;
    if (cycles == 6000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Expectations and drivers
  // ----------------------------------------
  // Feedback pattern expected for one captured command in either mapping.
  function automatic logic [15:0] fb(input logic [9:0] rv, input logic [9:0] fv, input logic rm);
    int idx[8] = '{0, 1, 2, 3, 5, 6, 7, 8};
    logic [15:0] v;
    v = 16'h0000;
    if (rm)
      v = {6'h00, fv[9], rv[9], 6'h00, fv[4], rv[4]};
    else
      for (int k = 0; k < 8; k++)
        v[2*k +: 2] = {fv[idx[k]], rv[idx[k]]};
    return v;
  endfunction

  // A register write: rising edge holds the low six address bits, falling the rest.
  task automatic mrw(input logic [7:0] adr, input logic [7:0] op);
    zqc_ctrl_model_i.cycle({adr[5:0], 4'h0}, {op, adr[7:6]}, 1'b1, 1'b0);
    repeat (10) @(posedge clk_sys);
  endtask

  // One calibration with a count of the busy and pin-enable cycles that follow.
  task automatic cal(input logic [7:0] op, input int exp_cyc);
    busy_cyc = 0;
    pin_cyc = 0;
    mrw(ZQC_MR_CAL, op);
    repeat (ZQC_INIT_CYC + 20) @(posedge clk_sys);
    `CHK(busy_cyc, exp_cyc)
    `CHK(pin_cyc, exp_cyc)
  endtask

  // Training commands with random and extreme CA values, checked on the data lines.
  task automatic train(input logic rm);
    for (int i = 0; i < 6; i++)
    begin
      r = (i == 0) ? 10'h3ff : 10'($urandom) | 10'h001;
      f = (i == 0) ? 10'h000 : 10'($urandom);
      zqc_ctrl_model_i.cycle(r, f, 1'b1, 1'b0);
      repeat (10) @(posedge clk_sys);
      if (rm)
        `CHK(dq_o, fb(r, f, 1'b1))
      else
        `CHK(dq_o, fb(r, f, 1'b0))
      `CHK(dq_oe, 16'hffff)
      `CHK(dqs_oe, 1'b0)
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  // Termination stays off for calibration, on during training to show it is gated.
  initial
  begin
    rst = 1'b1;
    odt_pin = 1'b0;
    void'($urandom(32'haf96));
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK(imp_default, 1'b1)
    cal(ZQC_OP_INIT, ZQC_INIT_CYC);
    cal(ZQC_OP_LONG, ZQC_LONG_CYC);
    `CHK(imp_default, 1'b0)
    cal(ZQC_OP_SHORT, ZQC_SHORT_CYC);
    cal(ZQC_OP_RESET, 0);
    `CHK(imp_default, 1'b1)
    busy_cyc = 0;
    mrw(ZQC_MR_CAL, ZQC_OP_INIT);
    mrw(ZQC_MR_CAL, ZQC_OP_LONG);
    repeat (ZQC_INIT_CYC + 20) @(posedge clk_sys);
    `CHK(busy_cyc, ZQC_INIT_CYC)
    odt_pin <= 1'b1;
    // The entry write is framed by deselected cycles with the bus held still.
    zqc_ctrl_model_i.cycle(ENT_CA, ENT_CA, 1'b0, 1'b1);
    zqc_ctrl_model_i.cycle(ENT_CA, ENT_CA, 1'b1, 1'b1);
    zqc_ctrl_model_i.cycle(ENT_CA, ENT_CA, 1'b0, 1'b0);
    repeat (10) @(posedge clk_sys);
    `CHK(train_mode, 1'b1)
    `CHK(odt_on, 1'b0)
    cal(ZQC_OP_LONG, 0);
    train(1'b0);
    mrw(ZQC_MR_ENTRY, ZQC_OP_ENTRY);
    `CHK(train_mode, 1'b1)
    `CHK(dq_o, fb(ENT_CA, ENT_CA, 1'b0))
    mrw(ZQC_MR_REMAP, ZQC_OP_REMAP);
    `CHK(remap_mode, 1'b1)
    train(1'b1);
    zqc_ctrl_model_i.skew();
    repeat (10) @(posedge clk_sys);
    `CHK(dq_o, fb(r, f, 1'b1))
    `CHK(remap_mode, 1'b1)
    mrw(ZQC_MR_EXIT, ZQC_OP_EXIT);
    `CHK(train_mode, 1'b0)
    `CHK(dq_oe, 16'h0000)
    `CHK(odt_on, 1'b1)
    mrw(ZQC_MR_REMAP, ZQC_OP_REMAP);
    `CHK(remap_mode, 1'b0)
    give_verdict();
  end
endmodule
`default_nettype wire

// ### zqc_ctrl_model.sv
// Controller-side model that drives the memory clock and command pins.
`timescale 1ns/1ps
`default_nettype none
module zqc_ctrl_model (
  input wire logic clk_sys, // System clock that paces every pin change.
  output logic ck_t, // Memory clock, still between frames.
  output logic cke, // Clock enable.
  output logic cs_n, // Chip select, active low.
  output logic [9:0] ca // Command/address bus.
);
  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Pins idle with the clock low and chip select high, which reads as no operation.
  initial
  begin
    ck_t <= 1'b0;
    cke <= 1'b1;
    cs_n <= 1'b1;
    ca <= 10'h000;
  end

  // One memory clock cycle of nine system clocks; every pin moves on a rising edge.
  // Clock enable stays high so calibration and remap both see it.
  task automatic cycle(input logic [9:0] r, input logic [9:0] f, input logic sel,
    input logic keep);
  begin
    @(posedge clk_sys);
    cs_n <= ~sel;
    cke <= 1'b1;
    ca <= r;
    @(posedge clk_sys);
    ck_t <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ca <= f;
    @(posedge clk_sys);
    ck_t <= 1'b0;
    repeat (3) @(posedge clk_sys);
    cs_n <= 1'b1;
    // A released bus shows the inverse, so a stale sample cannot pass by luck.
    if (!keep)
      ca <= ~f;
  end
  endtask

  // Deselected clock with clock enable low and uneven pulses, as a phase shift gives.
  task automatic skew();
  begin
    @(posedge clk_sys);
    cke <= 1'b0;
    ck_t <= 1'b1;
    repeat (2) @(posedge clk_sys);
    ck_t <= 1'b0;
    @(posedge clk_sys);
    ck_t <= 1'b1;
    repeat (5) @(posedge clk_sys);
    ck_t <= 1'b0;
    @(posedge clk_sys);
    cke <= 1'b1;
  end
  endtask
endmodule
`default_nettype wire

// ### zqc_pkg.sv
// Constants shared by the impedance calibration and CA training block.
// What this block does
// - A register write with a calibration operand starts that calibration when decoded outside CA training while no calibration is running.
// - Reset calibration restores default impedance; no quiet period follows it.
// - Calibration pin circuitry switches off when a calibration finishes.
// - Unused feedback lines drive valid levels; strobes stay static.
// - Feedback follows captured samples; delays counted from falling clock edge.
// - Repeated writes allowed; feedback delay restarts after last chip select.
// - Exit high impedance delay counts from first exit write falling edge.
// - Entry and exit writes decode before CA training, same on both edges.
// - After remap, CA4 and CA9 samples appear on DQ 0, 1, 8, 9.
// - Entry 0x29/0xa4, exit 0x2a/0xa8, remap 0x30/0xc0 on both edges.
// - First mapping: eight CA lines to DQ pairs, rising even, falling odd.
// - Second mapping: CA4 on DQ0/DQ1, CA9 on DQ8/DQ9.
// - Termination stays off for the whole training mode.
package zqc_pkg;
  localparam logic [7:0] ZQC_MR_CAL = 8'h0a;
  localparam logic [7:0] ZQC_OP_INIT = 8'hff;
  localparam logic [7:0] ZQC_OP_LONG = 8'hab;
  localparam logic [7:0] ZQC_OP_SHORT = 8'h56;
  localparam logic [7:0] ZQC_OP_RESET = 8'hc3;
  localparam logic [7:0] ZQC_MR_ENTRY = 8'h29;
  localparam logic [7:0] ZQC_OP_ENTRY = 8'ha4;
  localparam logic [7:0] ZQC_MR_EXIT = 8'h2a;
  localparam logic [7:0] ZQC_OP_EXIT = 8'ha8;
  localparam logic [7:0] ZQC_MR_REMAP = 8'h30;
  localparam logic [7:0] ZQC_OP_REMAP = 8'hc0;
  localparam logic [3:0] ZQC_MRW_CODE = 4'h0;
  localparam int ZQC_CLK_MHZ = 20;
  localparam int ZQC_INIT_CAL_US = 1;
  localparam int ZQC_LONG_CAL_NS = 360;
  localparam int ZQC_SHORT_CAL_NS = 90;
  localparam int ZQC_RESET_CAL_NS = 50;
  localparam int ZQC_FB_DELAY_NS = 20;
  localparam int ZQC_HIZ_DELAY_NS = 20;
  localparam int ZQC_INIT_CYC = (ZQC_INIT_CAL_US * ZQC_CLK_MHZ);
  localparam int ZQC_LONG_CYC = (ZQC_LONG_CAL_NS * ZQC_CLK_MHZ + 999) / 1000;
  localparam int ZQC_SHORT_CYC = (ZQC_SHORT_CAL_NS * ZQC_CLK_MHZ + 999) / 1000;
  localparam int ZQC_RESET_CYC = (ZQC_RESET_CAL_NS * ZQC_CLK_MHZ + 999) / 1000;
  localparam int ZQC_FB_CYC_RAW = (ZQC_FB_DELAY_NS * ZQC_CLK_MHZ + 999) / 1000;
  localparam int ZQC_FB_CYC = (ZQC_FB_CYC_RAW < 1) ? 1 : ZQC_FB_CYC_RAW;
  localparam int ZQC_HIZ_CYC_RAW = (ZQC_HIZ_DELAY_NS * ZQC_CLK_MHZ) / 1000;
  localparam int ZQC_HIZ_CYC = (ZQC_HIZ_CYC_RAW < 1) ? 1 : ZQC_HIZ_CYC_RAW;
  localparam int ZQC_CNT_W = 12;
  typedef enum logic [1:0] {ZQC_CAL_NONE, ZQC_CAL_INIT, ZQC_CAL_LONG, ZQC_CAL_SHORT} zqc_cal_t;
endpackage

// ### zqc_sync.sv
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module zqc_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [W-1:0] din, // Asynchronous input.
  output logic [W-1:0] dout // Synchronised output.
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      dout <= '0;
    end
    else
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### zqc_top.sv
// Device side impedance calibration and CA training command decoder.
`timescale 1ns/1ps
`default_nettype none
module zqc_top
  import zqc_pkg::*;
#(
  parameter int CA_W = 10,
  parameter int DQ_W = 16
) (
  input wire logic clk_sys, // System clock, 20 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic ck_t, // Memory clock pin, sampled.
  input wire logic cke, // Clock enable pin.
  input wire logic cs_n, // Chip select pin, active low.
  input wire logic [CA_W-1:0] ca, // Command/address bus pins.
  input wire logic odt_pin, // Termination control pin.
  output logic [DQ_W-1:0] dq_o, // Data outputs.
  output logic [DQ_W-1:0] dq_oe, // Data output enables.
  output logic dqs_oe, // Strobe output enable, held low.
  output logic odt_on, // Termination actually enabled.
  output logic zq_pin_en, // Calibration pin circuitry enable.
  output logic cal_busy, // Calibration period running.
  output logic imp_default, // Impedance is at default setting.
  output logic train_mode, // CA training mode active.
  output logic remap_mode // Second training mapping active.
);
  // ----------------------------------------------------------------
  // Pin sampling and clock edge detection
  // ----------------------------------------------------------------
  logic [CA_W+2:0] pins_s;
  logic ck_d_r, ck_rise, ck_fall;
  logic cke_s, cs_n_s, odt_s;
  logic [CA_W-1:0] ca_s, ca_rise_r, ca_fall_r;
  logic cmd_r, cs_seen_r;

  zqc_sync #(.W(CA_W+3)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din({ck_t, cke, cs_n, ca}),
    .dout(pins_s)
  );

  // Odt pin is asynchronous by nature; a level sync is enough.
  zqc_sync #(.W(1)) u_odt (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(odt_pin),
    .dout(odt_s)
  );

  assign ca_s = pins_s[CA_W-1:0];
  assign cs_n_s = pins_s[CA_W];
  assign cke_s = pins_s[CA_W+1];
  assign ck_rise = pins_s[CA_W+2] && !ck_d_r;
  assign ck_fall = !pins_s[CA_W+2] && ck_d_r;

  // Capture CA on both memory clock edges; a command completes at the fall.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ck_d_r <= 1'b0;
      ca_rise_r <= '0;
      ca_fall_r <= '0;
      cs_seen_r <= 1'b0;
      cmd_r <= 1'b0;
    end
    else
    begin
      ck_d_r <= pins_s[CA_W+2];
      cmd_r <= ck_fall && cs_seen_r;
      if (ck_rise)
      begin
        ca_rise_r <= ca_s;
        cs_seen_r <= !cs_n_s && cke_s;
      end
      if (ck_fall)
        ca_fall_r <= ca_s;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Returns the register address and operand of a mode register write.
  // The two top address bits ride on the falling edge, the low six on the rising edge.
  // This order is what makes the entry and exit codes equal on both edges.
  function automatic logic [15:0] mrw_fields(input logic [9:0] r, input logic [9:0] f);
    mrw_fields = {f[1:0], r[9:4], f[9:2]};
  endfunction

  logic [15:0] mrw;
  logic is_mrw, hit_entry, hit_exit, hit_remap, hit_cal;
  assign mrw = mrw_fields(ca_rise_r, ca_fall_r);
  assign is_mrw = cmd_r && (ca_rise_r[3:0] == ZQC_MRW_CODE);
  // Entry and exit codes equal on both edges, so they decode untrained.
  assign hit_entry = is_mrw && (mrw == {ZQC_MR_ENTRY, ZQC_OP_ENTRY}) && (ca_rise_r == ca_fall_r);
  assign hit_exit = is_mrw && (mrw == {ZQC_MR_EXIT, ZQC_OP_EXIT}) && (ca_rise_r == ca_fall_r);
  assign hit_remap = is_mrw && (mrw == {ZQC_MR_REMAP, ZQC_OP_REMAP}) && train_mode;
  assign hit_cal = is_mrw && (mrw[15:8] == ZQC_MR_CAL) && !train_mode;

  // ----------------------------------------------------------------
  // Impedance calibration
  // ----------------------------------------------------------------
  logic [ZQC_CNT_W-1:0] cal_cnt_r;
  zqc_cal_t cal_kind_r;

  // Decoding the operand while idle starts the selected calibration; reset acts at once.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cal_cnt_r <= '0;
      cal_kind_r <= ZQC_CAL_NONE;
      cal_busy <= 1'b0;
      zq_pin_en <= 1'b0;
      imp_default <= 1'b1;
    end
    else if (hit_cal && !cal_busy)
    begin
      case (mrw[7:0])
        ZQC_OP_INIT:
        begin
          cal_cnt_r <= ZQC_CNT_W'(ZQC_INIT_CYC);
          cal_kind_r <= ZQC_CAL_INIT;
          cal_busy <= 1'b1;
          zq_pin_en <= 1'b1;
        end
        ZQC_OP_LONG:
        begin
          cal_cnt_r <= ZQC_CNT_W'(ZQC_LONG_CYC);
          cal_kind_r <= ZQC_CAL_LONG;
          cal_busy <= 1'b1;
          zq_pin_en <= 1'b1;
        end
        ZQC_OP_SHORT:
        begin
          cal_cnt_r <= ZQC_CNT_W'(ZQC_SHORT_CYC);
          cal_kind_r <= ZQC_CAL_SHORT;
          cal_busy <= 1'b1;
          zq_pin_en <= 1'b1;
        end
        ZQC_OP_RESET:
          imp_default <= 1'b1;
        default:
          cal_kind_r <= cal_kind_r;
      endcase
    end
    else if (cal_busy)
    begin
      cal_cnt_r <= cal_cnt_r - 1'b1;
      if (cal_cnt_r == ZQC_CNT_W'(1))
      begin
        cal_busy <= 1'b0;
        zq_pin_en <= 1'b0;
        cal_kind_r <= ZQC_CAL_NONE;
        imp_default <= 1'b0;
      end
    end
  end

  chk_cal_pin_off: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(cal_busy) |-> !zq_pin_en && !$past(hit_cal)) else $error("pin not off");
  chk_cal_start: assert property (@(posedge clk_sys) disable iff (rst)
    hit_cal && !cal_busy && (mrw[7:0] == ZQC_OP_SHORT) |=> cal_busy [*2])
    else $error("short cal did not start");
  chk_cal_reset: assert property (@(posedge clk_sys) disable iff (rst)
    hit_cal && !cal_busy && (mrw[7:0] == ZQC_OP_RESET) |=> imp_default && !cal_busy)
    else $error("reset cal wrong");

  // ----------------------------------------------------------------
  // CA training mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      train_mode <= 1'b0;
      remap_mode <= 1'b0;
    end
    else if (hit_exit)
    begin
      train_mode <= 1'b0;
      remap_mode <= 1'b0;
    end
    else if (hit_entry && !cal_busy)
      train_mode <= 1'b1; // Repeated entry writes simply hold the mode.
    else if (hit_remap)
      remap_mode <= 1'b1;
  end

  // Termination forced off while training or calibrating.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      odt_on <= 1'b0;
    else
      odt_on <= odt_s && !train_mode && !hit_entry && !cal_busy;
  end

  chk_odt_train: assert property (@(posedge clk_sys) disable iff (rst)
    train_mode |=> !odt_on) else $error("odt on in training");
  chk_exit_decode: assert property (@(posedge clk_sys) disable iff (rst)
    hit_exit |=> !train_mode && !remap_mode) else $error("exit not taken");

  // ----------------------------------------------------------------
  // Training feedback
  // ----------------------------------------------------------------
  // Delays run on the system clock from the falling edge of the last
  // registered command; the analog delay is approximated in whole cycles.
  localparam int FB_DLY = ZQC_FB_CYC;
  logic [3:0] fb_cnt_r, hiz_cnt_r;
  logic [DQ_W-1:0] fb_map;
  logic train_cmd;
  assign train_cmd = cmd_r && train_mode && !hit_exit;

  // Builds the DQ pattern from rising and falling samples per mapping.
  function automatic logic [15:0] map_dq(input logic [9:0] r, input logic [9:0] f, input logic m2);
    logic [15:0] d;
    d = '0;
    if (m2)
    begin
      d[0] = r[4];
      d[1] = f[4];
      d[8] = r[9];
      d[9] = f[9];
    end
    else
    begin
      d[1:0] = {f[0], r[0]};
      d[3:2] = {f[1], r[1]};
      d[5:4] = {f[2], r[2]};
      d[7:6] = {f[3], r[3]};
      d[9:8] = {f[5], r[5]};
      d[11:10] = {f[6], r[6]};
      d[13:12] = {f[7], r[7]};
      d[15:14] = {f[8], r[8]};
    end
    map_dq = d;
  endfunction

  assign fb_map = map_dq(ca_rise_r, ca_fall_r, remap_mode);

  // Feedback delay restarts on every registered command in training mode except an exit write.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      fb_cnt_r <= '0;
      dq_o <= '0;
      dq_oe <= '0;
      dqs_oe <= 1'b0;
    end
    else
    begin
      dqs_oe <= 1'b0;
      if (hiz_cnt_r == 4'(1))
        dq_oe <= '0;
      if (train_cmd)
      begin
        fb_cnt_r <= 4'(ZQC_FB_CYC);
        dq_o <= fb_map; // Unused lines drive a valid low.
      end
      else if (fb_cnt_r != '0)
      begin
        fb_cnt_r <= fb_cnt_r - 1'b1;
        if (fb_cnt_r == 4'(1))
          dq_oe <= '1;
      end
    end
  end

  // High impedance delay counted from the first exit write.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      hiz_cnt_r <= '0;
    else if (hit_exit && train_mode)
      hiz_cnt_r <= 4'(ZQC_HIZ_CYC);
    else if (hiz_cnt_r != '0)
      hiz_cnt_r <= hiz_cnt_r - 1'b1;
  end

  sequence s_train_cmd;
    train_cmd && !hit_exit;
  endsequence
  sequence s_fb_valid;
    ##(FB_DLY) dq_oe[0];
  endsequence
  // Once driven, feedback must stay on the lines while no new command arrives.
  property p_fb;
    @(posedge clk_sys) disable iff (rst) s_train_cmd ##1 (!cmd_r [*4]) |-> dq_oe == '1;
  endproperty
  chk_fb_hold: assert property (p_fb) else $error("feedback dropped");
  chk_fb_valid: assert property (@(posedge clk_sys) disable iff (rst)
    s_train_cmd ##1 !cmd_r |-> s_fb_valid) else $error("feedback late");
  chk_fb_hiz: assert property (@(posedge clk_sys) disable iff (rst)
    hit_exit && train_mode |-> ##[1:4] dq_oe == '0) else $error("no hiz after exit");
  chk_fb_strobe: assert property (@(posedge clk_sys) disable iff (rst)
    dq_oe[0] |-> !dqs_oe) else $error("strobe moved");
  chk_fb_remap: assert property (@(posedge clk_sys) disable iff (rst)
    train_cmd && remap_mode |=> dq_o[9] == $past(ca_fall_r[9]) && dq_o[2] == 1'b0)
    else $error("remap data wrong");
endmodule
`default_nettype wire
